//--- common/pcisc_pkg.sv
// Purpose: Shared constants and types of the configuration status and
//          class identification block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Offsets are configuration-space byte offsets.
package pcisc_pkg;

   // ****************************************************************
   // Register offsets and field positions.
   // ****************************************************************
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h06;
   localparam logic [7:0] CLASS_OFS = 8'h08;
   localparam int PARITY_RESP_BIT = 6;
   localparam int SERR_ENABLE_BIT = 8;
   localparam int DET_PAR_BIT = 15;
   localparam int SIG_SERR_BIT = 14;
   localparam int RCV_MASTER_ABORT_BIT = 13;
   localparam int RCV_TABORT_BIT = 12;
   localparam int SIG_TABORT_BIT = 11;
   localparam int MST_DPAR_BIT = 8;
   localparam logic [15:0] STATUS_RESET = 16'h0210;
   localparam logic [15:0] STATUS_FIXED = 16'h0210;
   localparam logic [15:0] STATUS_STICKY = 16'hf900;
   localparam logic [15:0] CMD_WRITABLE = 16'h0140;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam int DEVSEL_LSB = 9;

   // ****************************************************************
   // Class code fields.
   // ****************************************************************
   localparam logic [7:0] BASE_CLASS_SERIAL = 8'h0c;
   localparam logic [7:0] SUB_CLASS_1394 = 8'h00;
   localparam logic [7:0] PROG_IF_OPEN_HC = 8'h10;
   // Cycles from the address phase to the claim: medium timing.
   localparam int DEVSEL_WAIT_CYCLES = 2;

   // ****************************************************************
   // Carriers.
   // ****************************************************************
   typedef struct packed {
      logic addr_par;
      logic data_par;
      logic perr_seen;
      logic master_xfer;
      logic master_abort;
      logic tabort_rcv;
      logic signaled_target_abort_flag;
      logic serr_req;
   } pcisc_evt_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pcisc_cfg_t;

   typedef enum logic [2:0] {
      DS_IDLE = 3'h1,
      DS_WAIT = 3'h2,
      DS_CLAIM = 3'h4
   } pcisc_ds_state_t;

endpackage

//--- core/pcisc_devsel.sv
// Purpose: Claims a decoded transaction with medium select timing.
// Assumes: i_addr_phase marks the address phase clock of a transaction.
// Notes:   The claim holds until the bus logic reports the end.
`timescale 1ns/1ps
module pcisc_devsel
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_addr_phase,
   input wire logic i_hit,
   input wire logic i_xfer_end,
   output logic o_devsel_on
);

   typedef struct packed {
      pcisc_pkg::pcisc_ds_state_t st;
      logic claim;
   } pcisc_ds_regs_t;

   pcisc_ds_regs_t r;
   pcisc_ds_regs_t next_r;

   // ****************************************************************
   // Claim sequencer.
   // ****************************************************************
   // A hit waits one extra clock so the claim lands in the second clock
   // after the address phase, never the first.
   always_comb
   begin
      next_r = r;
      unique case (r.st)
         pcisc_pkg::DS_IDLE:
         begin
            if (i_addr_phase && i_hit)
            begin
               next_r.st = pcisc_pkg::DS_WAIT;
            end
         end
         pcisc_pkg::DS_WAIT:
         begin
            next_r.st = pcisc_pkg::DS_CLAIM;
            next_r.claim = 1'b1;
         end
         pcisc_pkg::DS_CLAIM:
         begin
            if (i_xfer_end)
            begin
               next_r.st = pcisc_pkg::DS_IDLE;
               next_r.claim = 1'b0;
            end
         end
         default:
         begin
            next_r.st = pcisc_pkg::DS_IDLE;
            next_r.claim = 1'b0;
         end
      endcase
   end

   // Registered state; reset parks the sequencer with no claim.
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         r.st <= pcisc_pkg::DS_IDLE;
         r.claim <= 1'b0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign o_devsel_on = r.claim;

   a_devsel_medium: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      (r.st == pcisc_pkg::DS_IDLE && i_addr_phase && i_hit)
      |=> !o_devsel_on ##1 o_devsel_on)
      else $error("Select claim not at medium timing.");

endmodule

//--- core/pcisc_top.sv
// Purpose: Status and class identification registers of the bus function,
//          with the command enables that gate error signalling.
// Assumes: Event inputs come from bus logic on the same clock.
// Notes:   Config port is dword addressed with byte enables.
//
// Function
// - Parity error detected sets status bit 15.
// - Signalled system error sets status bit 14.
// - Own cycle master abort sets bit 13.
// - Own cycle target abort sets bit 12.
// - Issuing target abort sets bit 11.
// - Select timing reads 01b; claim medium timing.
// - Master data parity needs error, mastering, enable.
// - Status bit 7 always reads zero.
// - Status bit 6 always reads zero.
// - Status bit 5 always reads zero.
// - Status bit 4 always reads one.
// - Status bits 3 to 0 read zero.
// - Base class field reads 0Ch.
// - Subclass field reads 00h.
// - Programming interface field reads 10h.
// - Silicon revision field fixed, always returned.
// - System error output only with its enable.
// - Parity error output only with response enable.
`timescale 1ns/1ps
module pcisc_top
#(
   // Arbitrary neutral revision value.
   parameter logic [7:0] SILICON_REVISION = 8'h5a
)
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input pcisc_pkg::pcisc_cfg_t i_cfg,
   input pcisc_pkg::pcisc_evt_t i_evt,
   input wire logic i_addr_phase,
   input wire logic i_hit,
   input wire logic i_xfer_end,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   output logic o_serr,
   output logic o_perr,
   output logic o_devsel_on
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic signaled_system_error_flag_en;
      logic parity_resp_en;
      logic [15:0] sticky;
      logic serr;
      logic perr;
      logic ack;
      logic [31:0] rdata;
   } pcisc_regs_t;

   pcisc_regs_t r;
   pcisc_regs_t next_r;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [5:0] dword;
   logic rd_cmd_status;
   logic rd_class;
   logic wr_cmd_status;

   // ****************************************************************
   // Functions.
   // ****************************************************************
   // Builds the status word from the sticky flags and the fixed bits.
   function automatic logic [15:0] status_word(input logic [15:0] flags);
      logic [15:0] w;
      w = flags & pcisc_pkg::STATUS_STICKY;
      w = w | pcisc_pkg::STATUS_FIXED;
      return w;
   endfunction

   // Builds the command word from the two implemented enables.
   function automatic logic [15:0] command_word(input logic serr_en,
                                                input logic parity_en);
      logic [15:0] w;
      w = 16'h0000;
      w[pcisc_pkg::SERR_ENABLE_BIT] = serr_en;
      w[pcisc_pkg::PARITY_RESP_BIT] = parity_en;
      return w;
   endfunction

   // The fixed class and revision dword.
   function automatic logic [31:0] class_word(input logic [7:0] rev);
      return {pcisc_pkg::BASE_CLASS_SERIAL, pcisc_pkg::SUB_CLASS_1394,
              pcisc_pkg::PROG_IF_OPEN_HC, rev};
   endfunction

   // ****************************************************************
   // Address decode.
   // ****************************************************************
   // The status half-word shares its dword with the command half-word,
   // so both decode to the same dword index.
   assign dword = i_cfg.addr[7:2];
   assign rd_cmd_status = i_cfg.rd && (dword == pcisc_pkg::CMD_OFS[7:2]);
   assign rd_class = i_cfg.rd && (dword == pcisc_pkg::CLASS_OFS[7:2]);
   assign wr_cmd_status = i_cfg.wr && (dword == pcisc_pkg::STATUS_OFS[7:2]);

   // ****************************************************************
   // Event collection.
   // ****************************************************************
   // Each hardware event maps onto its sticky status position.
   always_comb
   begin
      set_vec = 16'h0000;
      set_vec[pcisc_pkg::DET_PAR_BIT] = i_evt.addr_par
                                        | i_evt.data_par;
      set_vec[pcisc_pkg::SIG_SERR_BIT] = r.serr;
      set_vec[pcisc_pkg::RCV_MASTER_ABORT_BIT] = i_evt.master_abort;
      set_vec[pcisc_pkg::RCV_TABORT_BIT] = i_evt.tabort_rcv;
      set_vec[pcisc_pkg::SIG_TABORT_BIT] = i_evt.signaled_target_abort_flag;
      set_vec[pcisc_pkg::MST_DPAR_BIT] = i_evt.perr_seen
                                         & i_evt.master_xfer
                                         & r.parity_resp_en;
   end

   // Write-one-clear comes only through the upper status byte lane,
   // since every low status bit is read-only.
   always_comb
   begin
      clr_vec = 16'h0000;
      if (wr_cmd_status && i_cfg.be[3])
      begin
         clr_vec[15:8] = i_cfg.wdata[31:24];
      end
   end

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb
   begin
      next_r = r;
      // Set wins over clear so an event in the clearing cycle survives.
      next_r.sticky = ((r.sticky & ~clr_vec) | set_vec)
                      & pcisc_pkg::STATUS_STICKY;
      // Command enables, written through the low byte lanes.
      if (wr_cmd_status && i_cfg.be[0])
      begin
         next_r.parity_resp_en = i_cfg.wdata[pcisc_pkg::PARITY_RESP_BIT];
      end
      if (wr_cmd_status && i_cfg.be[1])
      begin
         next_r.signaled_system_error_flag_en = i_cfg.wdata[pcisc_pkg::SERR_ENABLE_BIT];
      end
      // System error is driven for address parity or a request from the
      // bus logic, but never without its enable.
      next_r.serr = r.signaled_system_error_flag_en
                    & (i_evt.addr_par | i_evt.serr_req);
      // Parity error response is driven only with its enable set.
      next_r.perr = r.parity_resp_en & i_evt.data_par;
      // One-cycle answer to every access; unmapped reads return zero.
      next_r.ack = i_cfg.rd | i_cfg.wr;
      next_r.rdata = 32'h0000_0000;
      if (rd_cmd_status)
      begin
         next_r.rdata = {status_word(r.sticky),
                         command_word(r.signaled_system_error_flag_en,
                                      r.parity_resp_en)};
      end
      else if (rd_class)
      begin
         next_r.rdata = class_word(SILICON_REVISION);
      end
   end

   // ****************************************************************
   // Registers.
   // ****************************************************************
   // Reset leaves all flags clear, so status reads its reset value.
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         r.signaled_system_error_flag_en <= 1'b0;
         r.parity_resp_en <= 1'b0;
         r.sticky <= 16'h0000;
         r.serr <= 1'b0;
         r.perr <= 1'b0;
         r.ack <= 1'b0;
         r.rdata <= 32'h0000_0000;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign o_cfg_ack = r.ack;
   assign o_cfg_rdata = r.rdata;
   assign o_serr = r.serr;
   assign o_perr = r.perr;

   // ****************************************************************
   // Select timing.
   // ****************************************************************
   // The claim logic runs medium timing to match the advertised code.
   pcisc_devsel u_devsel
   (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_addr_phase(i_addr_phase),
      .i_hit(i_hit),
      .i_xfer_end(i_xfer_end),
      .o_devsel_on(o_devsel_on)
   );

   // ****************************************************************
   // Checks.
   // ****************************************************************
   a_parity_flag_set: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      (i_evt.addr_par || i_evt.data_par)
      |=> r.sticky[pcisc_pkg::DET_PAR_BIT])
      else $error("Detected parity flag not set.");

   a_serr_flag_set: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      o_serr |=> r.sticky[pcisc_pkg::SIG_SERR_BIT])
      else $error("Signalled system error flag not set.");

   a_serr_flag_cause: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      $rose(r.sticky[pcisc_pkg::SIG_SERR_BIT]) |-> $past(o_serr))
      else $error("System error flag set without signalling.");

   a_master_abort_flag: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      i_evt.master_abort |=> r.sticky[pcisc_pkg::RCV_MASTER_ABORT_BIT])
      else $error("Master abort flag not set.");

   a_tabort_rcv_flag: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      i_evt.tabort_rcv |=> r.sticky[pcisc_pkg::RCV_TABORT_BIT])
      else $error("Received target abort flag not set.");

   a_signaled_target_abort_flag_flag: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      i_evt.signaled_target_abort_flag |=> r.sticky[pcisc_pkg::SIG_TABORT_BIT])
      else $error("Signalled target abort flag not set.");

   a_status_fixed_bits: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      rd_cmd_status |=> o_cfg_ack
      && o_cfg_rdata[26:25] == pcisc_pkg::DEVSEL_MEDIUM
      && o_cfg_rdata[23:16] == 8'h10)
      else $error("Fixed status bits read wrong.");

   a_dpar_flag_gate: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      $rose(r.sticky[pcisc_pkg::MST_DPAR_BIT])
      |-> $past(i_evt.perr_seen) && $past(i_evt.master_xfer)
      && $past(r.parity_resp_en))
      else $error("Data parity flag set without all conditions.");

   a_class_read: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      rd_class |=> o_cfg_ack
      && o_cfg_rdata == {8'h0c, 8'h00, 8'h10, SILICON_REVISION})
      else $error("Class and revision dword read wrong.");

   a_serr_gated: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      o_serr |-> $past(r.signaled_system_error_flag_en))
      else $error("System error driven while disabled.");

   a_perr_gated: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      o_perr |-> $past(r.parity_resp_en) && $past(i_evt.data_par))
      else $error("Parity error driven while disabled.");

   a_w1c_clears: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      (wr_cmd_status && i_cfg.be[3]
       && i_cfg.wdata[24 + pcisc_pkg::RCV_MASTER_ABORT_BIT - 8]
       && !i_evt.master_abort)
      |=> !r.sticky[pcisc_pkg::RCV_MASTER_ABORT_BIT])
      else $error("Write one did not clear the flag.");

   a_w0_keeps: assert property (
      @(posedge i_mclk) disable iff (!i_rstn)
      (r.sticky[pcisc_pkg::DET_PAR_BIT]
       && !(wr_cmd_status && i_cfg.be[3] && i_cfg.wdata[31]))
      |=> r.sticky[pcisc_pkg::DET_PAR_BIT])
      else $error("Sticky flag lost without a write of one.");

endmodule

//--- bench/pcisc_bus_model.sv
// Purpose: Bus agent that runs one transaction toward the function.
// Assumes: It drives off the falling edge, like the bench.
// Notes:   i_len sets how long the data phase lasts before the end.
`timescale 1ns/1ps
module pcisc_bus_model
(
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic i_claim_me,
   input wire logic [3:0] i_len,
   output logic o_addr_phase,
   output logic o_hit,
   output logic o_xfer_end
);
   // ****************************************************************
   // Transaction sequencer.
   // ****************************************************************
   // The decode line flips outside the address phase, so a design that
   // looks at it there cannot get the right answer by luck.
   initial
   begin
      o_addr_phase = 1'b0;
      o_hit = 1'b0;
      o_xfer_end = 1'b0;
      forever
      begin
         @(posedge i_mclk iff i_go);
         @(negedge i_mclk);
         o_addr_phase = 1'b1;
         o_hit = i_claim_me;
         @(negedge i_mclk);
         o_addr_phase = 1'b0;
         o_hit = ~i_claim_me;
         // Only a claimed cycle has a data phase; the claim comes late.
         if (i_claim_me)
         begin
            repeat (2 + i_len) @(negedge i_mclk);
            o_xfer_end = 1'b1;
            @(negedge i_mclk);
            o_xfer_end = 1'b0;
         end
      end
   end
endmodule

//--- bench/pci_config_status_class_tb_top.sv
// Purpose: Self-checking bench of the status and class registers.
// Assumes: Stimulus changes at the falling edge only.
// Notes:   A software model of status and command predicts each read.
`timescale 1ns/1ps
module pci_config_status_class_tb_top;
   // Arbitrary revision value, chosen to differ from the default.
   localparam logic [7:0] REV = 8'h3c;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   pcisc_pkg::pcisc_cfg_t cfg = '0;
   pcisc_pkg::pcisc_evt_t evt = '0;
   logic go = 1'b0;
   logic claim_me = 1'b0;
   logic [3:0] len = 4'h0;
   logic addr_phase, hit, xfer_end, ack, serr, perr, devsel_on;
   logic [31:0] rdata;
   logic [15:0] st = pcisc_pkg::STATUS_RESET;
   logic [15:0] cmd = 16'h0000;
   logic [15:0] seed = 16'hdb11;
   int n_errors = 0;
   int checked = 0;
   int cnt;

   // 10 MHz clock.
   always #50 i_mclk = ~i_mclk;

   pcisc_top #(.SILICON_REVISION(REV)) dut_u (.i_mclk(i_mclk),
      .i_rstn(i_rstn), .i_cfg(cfg), .i_evt(evt),
      .i_addr_phase(addr_phase), .i_hit(hit), .i_xfer_end(xfer_end),
      .o_cfg_ack(ack), .o_cfg_rdata(rdata), .o_serr(serr),
      .o_perr(perr), .o_devsel_on(devsel_on));

   pcisc_bus_model bus_u (.i_mclk(i_mclk), .i_go(go),
      .i_claim_me(claim_me), .i_len(len), .o_addr_phase(addr_phase),
      .o_hit(hit), .o_xfer_end(xfer_end));

   // ****************************************************************
   // Prediction and comparison.
   // ****************************************************************
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Read data expected for a dword; unmapped places read zero.
   function automatic logic [31:0] exp_read(input logic [7:0] a);
      case (a[7:2])
         6'h01: return {st, cmd};
         6'h02: return {pcisc_pkg::BASE_CLASS_SERIAL,
            pcisc_pkg::SUB_CLASS_1394, pcisc_pkg::PROG_IF_OPEN_HC, REV};
         default: return 32'h0000_0000;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // One access and/or event pulse, then every output that it causes.
   task automatic cycle(input pcisc_pkg::pcisc_evt_t e, input logic rd,
      input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd);
      logic [31:0] x;
      logic [15:0] set;
      logic [15:0] clr;
      logic hit_cmd;
      begin
         x = rd ? exp_read(a) : 32'h0000_0000;
         hit_cmd = wr && a[7:2] == 6'h01;
         set = {e.addr_par | e.data_par, (e.addr_par | e.serr_req)
            & cmd[8], e.master_abort, e.tabort_rcv, e.signaled_target_abort_flag, 2'b00,
            e.perr_seen & e.master_xfer & cmd[6], 8'h00};
         clr = (hit_cmd && be[3]) ? ({wd[31:24], 8'h00}
            & pcisc_pkg::STATUS_STICKY) : 16'h0000;
         @(negedge i_mclk);
         cfg = '{rd: rd, wr: wr, addr: a, be: be, wdata: wd};
         evt = e;
         @(negedge i_mclk);
         // Registered answers stand only until the next rising edge,
         // so they are sampled at this falling edge.
         chk("ack", 32'(rd | wr), 32'(ack));
         chk("rdata", x, rdata);
         chk("serr", 32'((e.addr_par | e.serr_req) & cmd[8]),
            32'(serr));
         chk("perr", 32'(e.data_par & cmd[6]), 32'(perr));
         cfg.rd = 1'b0;
         cfg.wr = 1'b0;
         evt = '0;
         st = (st & ~clr) | set;
         if (hit_cmd && be[0])
            cmd[6] = wd[6];
         if (hit_cmd && be[1])
            cmd[8] = wd[8];
      end
   endtask

   // Runs one bus transaction and times the claim against it.
   task automatic claim(input logic h, input logic [3:0] l);
      @(negedge i_mclk);
      go = 1'b1;
      claim_me = h;
      len = l;
      @(negedge i_mclk);
      go = 1'b0;
      // The address phase is sampled at the next rising edge; the claim
      // must still be low after it and high one edge later.
      repeat (1) @(negedge i_mclk);
      chk("devsel early", 32'h0000_0000, 32'(devsel_on));
      @(negedge i_mclk);
      chk("devsel medium", 32'(h), 32'(devsel_on));
      cnt = 0;
      while (devsel_on === 1'b1 && cnt < 20)
      begin
         cnt++;
         @(negedge i_mclk);
      end
      // The agent ends the data phase two clocks plus the length after
      // the address phase, so the claim is seen for length plus two.
      chk("claim length", h ? 32'(l) + 2 : 0, 32'(cnt));
      // A claim that never drops has already counted a mismatch.
      if (cnt >= 20)
         final_report();
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial
   begin
      repeat (20) @(negedge i_mclk);
      i_rstn = 1'b1;
      cycle('0, 1'b1, 1'b0, 8'h06, 4'h0, 32'h0);
      cycle('0, 1'b0, 1'b1, 8'h08, 4'hf, 32'hffff_ffff);
      cycle('0, 1'b1, 1'b0, 8'h08, 4'h0, 32'h0);
      cycle('0, 1'b1, 1'b0, 8'h0c, 4'h0, 32'h0);
      // Each event alone beside master_xfer, with both enables off and then on.
      for (int en = 0; en < 2; en++)
      begin
         cycle('0, 1'b0, 1'b1, 8'h04, 4'h3, en ? 32'h0000_0140 : 0);
         for (int b = 0; b < 8; b++)
         begin
            cycle(8'h10 | (8'h80 >> b), 1'b0, 1'b0, 8'h04, 4'h0, 0);
            cycle('0, 1'b1, 1'b0, 8'h04, 4'h0, 0);
            cycle('0, 1'b0, 1'b1, 8'h06, 4'h8, 32'hffff_ffff);
         end
      end
      // A new event must win over a clear in the same cycle.
      cycle(8'h08, 1'b0, 1'b1, 8'h04, 4'h8, 32'h2000_0000);
      cycle('0, 1'b1, 1'b0, 8'h04, 4'h0, 0);
      // Random traffic: events, enables and partial clears mixed.
      for (int i = 0; i < 300; i++)
      begin
         seed = lfsr_next(seed);
         cycle(seed[7:0] & seed[15:8], 1'b0, seed[2], {4'h0, seed[3], 1'b1,
            2'h0}, seed[15:12], {seed, seed});
         cycle('0, 1'b1, 1'b0, 8'h04, 4'h0, 0);
      end
      // Reset in mid-run returns the reset pattern.
      @(negedge i_mclk);
      i_rstn = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_rstn = 1'b1;
      st = pcisc_pkg::STATUS_RESET;
      cmd = 16'h0000;
      cycle('0, 1'b1, 1'b0, 8'h04, 4'h0, 0);
      claim(1'b1, 4'h0);
      claim(1'b1, 4'h5);
      claim(1'b0, 4'h2);
      final_report();
   end

   // Cuts a hang short; running out counts as a mismatch.
   initial
   begin
      #5000000;
      n_errors++;
      final_report();
   end
endmodule
